// [audio_path_regs.v]
// apb register bank for audio path mode and ringer level control
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "audio_path_map.vh"
module audio_path_regs
(
   input  wire        i_clk,
   input  wire        i_reset_n,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [31:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output wire        o_pready,
   output reg  [31:0] o_prdata,
   output wire        o_pslverr,
   output wire [2:0]  o_gain_code,
   output wire        o_gain_valid,
   output wire        o_input_second,
   output wire        o_input_en,
   output wire        o_loop2,
   output wire        o_ear_en,
   output wire        o_spk_en,
   output wire        o_ring_en,
   output wire [3:0]  o_ring_level,
   output wire        o_ring_audible,
   output wire        o_hpf_en,
   output wire        o_autozero_en,
   output wire [7:0]  o_ringer_pitch
);
   // stored bytes and their next values; reserved bits are kept as written
   reg  [7:0]  mode_b_q;
   reg  [7:0]  mode_b_d;
   reg  [7:0]  mode_c_q;
   reg  [7:0]  mode_c_d;
   reg  [7:0]  level_q;
   reg  [7:0]  level_d;
   reg  [7:0]  pitch_q;
   reg  [7:0]  pitch_d;
   reg  [31:0] prdata_d;
   // bus qualifiers, decoded selects and per-register write strobes
   wire        access_w;
   wire        setup_rd_w;
   wire        wr_w;
   wire        hit_w;
   wire        we_mode_b_w;
   wire        we_mode_c_w;
   wire        we_level_w;
   wire        we_pitch_w;
   wire [7:0]  idx_w;
   wire [3:0]  sel_w;
   wire [7:0]  rd_byte_w;

   // bit positions inside the one-hot select word
   localparam SEL_MODE_B = 0;
   localparam SEL_MODE_C = 1;
   localparam SEL_LEVEL  = 2;
   localparam SEL_PITCH  = 3;

   // byte address is four times the register index
   function [7:0] word_index;
      input [31:0] addr;
      begin
         word_index = addr[9:2];
      end
   endfunction

   // only aligned words below the top of the index space answer
   function addr_in_range;
      input [31:0] addr;
      begin
         addr_in_range = (addr[1:0] == 2'h0) && (addr[31:10] == 22'h000000);
      end
   endfunction

   // one-hot select from an index; all zero for an unmapped index
   function [3:0] reg_select;
      input [7:0] idx;
      begin
         reg_select = 4'h0;
         case (idx)
            `ADDR_MODE_B:       reg_select[SEL_MODE_B] = 1'b1;
            `ADDR_MODE_C:       reg_select[SEL_MODE_C] = 1'b1;
            `ADDR_RINGER_LEVEL: reg_select[SEL_LEVEL]  = 1'b1;
            `ADDR_RINGER_PITCH: reg_select[SEL_PITCH]  = 1'b1;
            default:            reg_select = 4'h0;
         endcase
      end
   endfunction

   // and-or mux over the one-hot select; no select gives zero
   function [7:0] read_mux;
      input [3:0] sel;
      input [7:0] b_byte;
      input [7:0] c_byte;
      input [7:0] l_byte;
      input [7:0] p_byte;
      begin
         read_mux = ({8{sel[SEL_MODE_B]}} & b_byte)
                  | ({8{sel[SEL_MODE_C]}} & c_byte)
                  | ({8{sel[SEL_LEVEL]}} & l_byte)
                  | ({8{sel[SEL_PITCH]}} & p_byte);
      end
   endfunction

   // next value of one register: the bus byte on its write, else hold
   function [7:0] next_byte;
      input       we;
      input [7:0] wdata;
      input [7:0] cur;
      begin
         if (we)
            next_byte = wdata;
         else
            next_byte = cur;
      end
   endfunction

   // zero wait state; every access completes in its first access cycle
   assign o_pready   = 1'b1;
   assign access_w   = i_psel & i_penable;
   assign setup_rd_w = i_psel & ~i_penable & ~i_pwrite;
   assign wr_w       = access_w & i_pwrite;

   // misaligned or out-of-range addresses clear the select, so they never write
   assign idx_w      = word_index(i_paddr);
   assign sel_w      = reg_select(idx_w) & {4{addr_in_range(i_paddr)}};
   assign hit_w      = |sel_w;
   assign o_pslverr  = access_w & ~hit_w;

   // a write lands only at the access edge of a mapped word
   assign we_mode_b_w = wr_w & sel_w[SEL_MODE_B];
   assign we_mode_c_w = wr_w & sel_w[SEL_MODE_C];
   assign we_level_w  = wr_w & sel_w[SEL_LEVEL];
   assign we_pitch_w  = wr_w & sel_w[SEL_PITCH];

   // read byte for the selected word; unmapped words read as zero
   assign rd_byte_w  = read_mux(sel_w, mode_b_q, mode_c_q, level_q, pitch_q);

   // next value of the second mode register
   always @*
   begin
      mode_b_d = next_byte(we_mode_b_w, i_pwdata[7:0], mode_b_q);
   end

   // next value of the third mode register, reserved bit included
   always @*
   begin
      mode_c_d = next_byte(we_mode_c_w, i_pwdata[7:0], mode_c_q);
   end

   // next value of the ringer level register, low nibble included
   always @*
   begin
      level_d = next_byte(we_level_w, i_pwdata[7:0], level_q);
   end

   // next value of the ringer pitch register
   always @*
   begin
      pitch_d = next_byte(we_pitch_w, i_pwdata[7:0], pitch_q);
   end

   // read byte captured at the setup edge so it stands through the access cycle
   always @*
   begin
      if (setup_rd_w)
         prdata_d = {24'h000000, rd_byte_w};
      else
         prdata_d = o_prdata;
   end

   // second mode register; synchronous reset to zero
   always @(posedge i_clk)
   begin
      if (!i_reset_n)
         mode_b_q <= `RESET_BYTE;
      else
         mode_b_q <= mode_b_d;
   end

   // third mode register; synchronous reset to zero
   always @(posedge i_clk)
   begin
      if (!i_reset_n)
         mode_c_q <= `RESET_BYTE;
      else
         mode_c_q <= mode_c_d;
   end

   // ringer level register; reset leaves the ringer silent
   always @(posedge i_clk)
   begin
      if (!i_reset_n)
         level_q <= `RESET_BYTE;
      else
         level_q <= level_d;
   end

   // ringer pitch register; synchronous reset to zero
   always @(posedge i_clk)
   begin
      if (!i_reset_n)
         pitch_q <= `RESET_BYTE;
      else
         pitch_q <= pitch_d;
   end

   // read data register; a read changes no other state
   always @(posedge i_clk)
   begin
      if (!i_reset_n)
         o_prdata <= 32'h00000000;
      else
         o_prdata <= prdata_d;
   end

   // pitch byte goes straight out to the tone ringer
   assign o_ringer_pitch = pitch_q;

   // control decode kept apart so the mapping is easy to review
   audio_path_decode u_decode
   (
      .i_mode_b       (mode_b_q),
      .i_mode_c       (mode_c_q),
      .i_level        (level_q),
      .o_gain_code    (o_gain_code),
      .o_gain_valid   (o_gain_valid),
      .o_input_second (o_input_second),
      .o_input_en     (o_input_en),
      .o_loop2        (o_loop2),
      .o_ear_en       (o_ear_en),
      .o_spk_en       (o_spk_en),
      .o_ring_en      (o_ring_en),
      .o_ring_level   (o_ring_level),
      .o_ring_audible (o_ring_audible),
      .o_hpf_en       (o_hpf_en),
      .o_autozero_en  (o_autozero_en)
   );
endmodule
`default_nettype wire

// [audio_path_map.vh]
// register map, field positions and reset values for the audio path mode and ringer level bank
//Contract
//- bits 6..4 of audio_path_mode_c pick the pre-amp gain from 0 dB to +24 dB in 6 dB steps, codes 5..7 reserved.
//- bit 3 of audio_path_mode_c mutes both analog inputs when set.
//- bit 2 of audio_path_mode_c loops the converter output back internally and disables earpiece, loudspeaker and analog inputs.
//- bit 1 of audio_path_mode_c drives earpiece and loudspeaker together.
//- with bits 1 and 2 of audio_path_mode_c clear, exactly one output is on, chosen by bit 1 of audio_path_mode_b.
//- bit 0 of audio_path_mode_c enables the secondary tone ringer.
//- bits 7..4 of ringer_level give silence at 0, reserved at 1..5, and -27 dB to 0 dB in 3 dB steps at 6..15.
//- a zero in bit 5 of audio_path_mode_b keeps the mains rejection filter on, a zero in bit 6 keeps offset cancellation on.
//- reset clears both mode registers, the ringer level and the ringer pitch register to zero.
//- bit 1 of audio_path_mode_b selects the loudspeaker when set and the earpiece when clear.
`ifndef AUDIO_PATH_MAP_VH
`define AUDIO_PATH_MAP_VH

`define ADDR_MODE_B        8'h6A
`define ADDR_MODE_C        8'h6C
`define ADDR_RINGER_LEVEL  8'h6D
`define ADDR_RINGER_PITCH  8'h6E
`define RESET_BYTE         8'h00

`define MODE_B_IN_SEL      0
`define MODE_B_SPK_SEL     1
`define MODE_B_HPF_OFF     5
`define MODE_B_AZ_OFF      6
`define MODE_C_GAIN_HI     6
`define MODE_C_GAIN_LO     4
`define MODE_C_MUTE        3
`define MODE_C_LOOP2       2
`define MODE_C_BOTH        1
`define MODE_C_RING_EN     0
`define LEVEL_HI           7
`define LEVEL_LO           4

`define GAIN_MAX_CODE      3'h4
`define LEVEL_MIN_CODE     4'h6

`endif

// [audio_path_decode.v]
// decoder from the stored mode bytes to audio path control levels
`timescale 1ns/1ps
`default_nettype none
`include "audio_path_map.vh"
module audio_path_decode
(
   input  wire [7:0] i_mode_b,
   input  wire [7:0] i_mode_c,
   input  wire [7:0] i_level,
   output wire [2:0] o_gain_code,
   output wire       o_gain_valid,
   output wire       o_input_second,
   output wire       o_input_en,
   output wire       o_loop2,
   output wire       o_ear_en,
   output wire       o_spk_en,
   output wire       o_ring_en,
   output wire [3:0] o_ring_level,
   output wire       o_ring_audible,
   output wire       o_hpf_en,
   output wire       o_autozero_en
);
   wire both_w;
   wire spk_w;

   // gain code passes through; codes above +24 dB flagged as undefined
   assign o_gain_code    = i_mode_c[`MODE_C_GAIN_HI:`MODE_C_GAIN_LO];
   assign o_gain_valid   = (o_gain_code <= `GAIN_MAX_CODE);
   assign o_input_second = i_mode_b[`MODE_B_IN_SEL];
   // loopback overrides the earpiece, loudspeaker and input paths; the ringer enable is not gated
   assign o_loop2        = i_mode_c[`MODE_C_LOOP2];
   assign o_input_en     = ~i_mode_c[`MODE_C_MUTE] & ~o_loop2;
   assign both_w         = i_mode_c[`MODE_C_BOTH];
   assign spk_w          = i_mode_b[`MODE_B_SPK_SEL];
   assign o_ear_en       = ~o_loop2 & (both_w | ~spk_w);
   assign o_spk_en       = ~o_loop2 & (both_w | spk_w);
   assign o_ring_en      = i_mode_c[`MODE_C_RING_EN];
   // reserved levels 1..5 treated as silent; a safe choice for the speaker
   assign o_ring_level   = i_level[`LEVEL_HI:`LEVEL_LO];
   assign o_ring_audible = o_ring_en & (o_ring_level >= `LEVEL_MIN_CODE);
   assign o_hpf_en       = ~i_mode_b[`MODE_B_HPF_OFF];
   assign o_autozero_en  = ~i_mode_b[`MODE_B_AZ_OFF];
endmodule
`default_nettype wire

// [audio_path_regs_assertions.sv]
// assertions on the ports of the audio path register bank
`timescale 1ns/1ps
`default_nettype none
`include "audio_path_map.vh"
module audio_path_regs_chk
(
   input wire logic        i_clk,
   input wire logic        i_reset_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic        o_pslverr,
   input wire logic [2:0]  o_gain_code,
   input wire logic        o_gain_valid,
   input wire logic        o_input_second,
   input wire logic        o_input_en,
   input wire logic        o_loop2,
   input wire logic        o_ear_en,
   input wire logic        o_spk_en,
   input wire logic        o_ring_en,
   input wire logic [3:0]  o_ring_level,
   input wire logic        o_ring_audible,
   input wire logic        o_hpf_en,
   input wire logic        o_autozero_en,
   input wire logic [7:0]  o_ringer_pitch
);
   // write strobes; slave never stalls, so access phase is the commit edge
   wire logic acc = i_psel & i_penable & i_pwrite;
   wire logic wb = acc & (i_paddr == {22'h0, `ADDR_MODE_B, 2'b00});
   wire logic wc = acc & (i_paddr == {22'h0, `ADDR_MODE_C, 2'b00});
   wire logic wl = acc & (i_paddr == {22'h0, `ADDR_RINGER_LEVEL, 2'b00});
   wire logic wp = acc & (i_paddr == {22'h0, `ADDR_RINGER_PITCH, 2'b00});
   // any access phase, the four mapped words, and the unmapped word between the mode registers
   wire logic live = i_psel & i_penable;
   wire logic mapped = (i_paddr == {22'h0, `ADDR_MODE_B, 2'b00}) | (i_paddr == {22'h0, `ADDR_MODE_C, 2'b00})
      | (i_paddr == {22'h0, `ADDR_RINGER_LEVEL, 2'b00}) | (i_paddr == {22'h0, `ADDR_RINGER_PITCH, 2'b00});
   wire logic hole = (i_paddr == {22'h0, 8'h6B, 2'b00});
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   chk_gain_store: assert property (wc |=> o_gain_code == $past(i_pwdata[6:4])) else $error("gain code wrong");
   chk_gain_flag: assert property (wc |=> o_gain_valid == ($past(i_pwdata[6:4]) <= `GAIN_MAX_CODE))
      else $error("gain flag wrong");
   chk_input_pick: assert property (wb |=> o_input_second == $past(i_pwdata[0]))
      else $error("input select wrong");
   chk_pitch_store: assert property (wp |=> o_ringer_pitch == $past(i_pwdata[7:0]))
      else $error("pitch store wrong");
   chk_mapped_ok: assert property (live && mapped |-> !o_pslverr) else $error("error on mapped word");
   chk_hole_error: assert property (live && hole |-> o_pslverr) else $error("no error on hole");
   chk_mute_input: assert property (wc && i_pwdata[3] |=> !o_input_en) else $error("mute leaves input on");
   chk_loop_kill: assert property (o_loop2 |-> !(o_ear_en || o_spk_en || o_input_en)) else $error("loop leaks");
   chk_loop_store: assert property (wc |=> o_loop2 == $past(i_pwdata[2])) else $error("loop bit wrong");
   chk_both_drive: assert property (wc && i_pwdata[2:1] == 2'b01 |=> o_ear_en && o_spk_en) else $error("not both");
   chk_one_output: assert property (wb && !o_loop2 && !(o_ear_en && o_spk_en)
      |=> o_spk_en == $past(i_pwdata[1]) && o_ear_en != o_spk_en) else $error("output select wrong");
   chk_ring_enable: assert property (wc |=> o_ring_en == $past(i_pwdata[0])) else $error("ringer enable wrong");
   chk_ring_level: assert property (wl |=> o_ring_level == $past(i_pwdata[7:4])
      && o_ring_audible == (o_ring_en && $past(i_pwdata[7:4]) >= `LEVEL_MIN_CODE)) else $error("ringer level wrong");
   chk_filter_bits: assert property (wb |=> o_hpf_en == !$past(i_pwdata[5])
      && o_autozero_en == !$past(i_pwdata[6])) else $error("filter enables wrong");
endmodule
bind audio_path_regs audio_path_regs_chk u_chk (.*);
`default_nettype wire

// [tb.sv]
// self-checking bench for the audio path register bank
`timescale 1ns/1ps
`default_nettype none
`include "audio_path_map.vh"
`define CMP(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic        i_clk = 1'b0;
   logic        i_reset_n = 1'b0;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, o_prdata, e_v;
   logic        o_pready;
   logic [7:0]  mirror [5] = '{default: 8'h00};
   logic [7:0]  idx [5] = '{`ADDR_MODE_B, `ADDR_MODE_C, `ADDR_RINGER_LEVEL, `ADDR_RINGER_PITCH, 8'h6B};
   logic [7:0]  mask [5] = '{8'h1F, 8'h7F, 8'hF0, 8'hFF, 8'hFF}; // reserved and filter bits kept zero
   logic [31:0] exp_q [$];
   int          miscompares = 0, check_count = 0, seed = 19, i, k;
   always #10 i_clk = ~i_clk;
   audio_path_regs u_audio_path_regs (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(),
      .o_gain_code(), .o_gain_valid(), .o_input_second(), .o_input_en(), .o_loop2(), .o_ear_en(), .o_spk_en(),
      .o_ring_en(), .o_ring_level(), .o_ring_audible(), .o_hpf_en(), .o_autozero_en(), .o_ringer_pitch());
   task give_verdict;
      if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // one apb transfer; slot 4 is an unmapped word, so writes there are lost
   task apb(input logic wr, input int n, input logic [7:0] d);
      @(posedge i_clk);
      psel <= 1'b1; pwr <= wr; pen <= 1'b0;
      paddr <= {22'h0, idx[n], 2'b00};
      pwdata <= {24'h0, d};
      if (wr && n < 4) mirror[n] = d;
      if (!wr) exp_q.push_back({24'h0, mirror[n]});
      @(posedge i_clk);
      pen <= 1'b1;
      @(posedge i_clk);
      while (o_pready !== 1'b1) @(posedge i_clk);
      psel <= 1'b0; pen <= 1'b0;
   endtask
   // read results compared against the oldest note
   always @(posedge i_clk)
   begin
      if (psel && pen && !pwr && o_pready === 1'b1)
      begin
         e_v = exp_q.pop_front();
         `CMP(o_prdata, e_v)
      end
   end
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_reset_n <= 1'b1;
      for (i = 0; i < 5; i++) apb(1'b0, i, 8'h00);
      // sweep every gain, mute, loop, both, ringer and level code
      for (i = 0; i < 16; i++)
      begin
         apb(1'b1, 1, {1'b0, i[2:0], i[3:0]});
         apb(1'b1, 2, {i[3:0], 4'h0});
         apb(1'b1, 0, {1'b0, i[1:0], 3'h0, i[3], i[0]}); // filter bits set only as test work
         apb(1'b0, 1, 8'h00);
         apb(1'b0, 2, 8'h00);
      end
      // mid-run reset must clear every register again
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      mirror = '{default: 8'h00};
      for (i = 0; i < 5; i++) apb(1'b0, i, 8'h00);
      // random traffic, unmapped slot included
      for (k = 0; k < 40; k++)
      begin
         i = {$random(seed)} % 5;
         apb(1'b1, i, 8'($random(seed)) & mask[i]);
         apb(1'b0, i, 8'h00);
      end
      give_verdict;
   end
   // hang guard, about ten times the span the tests need
   initial
   begin
      #100000;
      miscompares++;
      give_verdict;
   end
endmodule
`default_nettype wire
